/* File: tb/hsu_bus_node.sv */
// far-side bus node: wired-and single wire with a pull-up
`timescale 1ns/1ns
`default_nettype none
module hsu_bus_node (
    input  wire logic clk_i,  // core clock
    input  wire logic txd_i,  // device drive, low pulls the wire down
    output logic      bus_o   // resolved wire level
);
    logic node_hi_q = 1'b1;   // node starts released
    // open drain: either party wins low, the pull-up gives high
    assign bus_o = txd_i & node_hi_q;
    // pull the wire low for lo cycles, then release it for hi cycles
    task automatic pulse(input int lo, input int hi);
        node_hi_q <= 1'b0;
        repeat (lo) @(posedge clk_i);
        node_hi_q <= 1'b1;
        repeat (hi) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: tb/test_hsu_sync_unit.sv */
// self-checking bench of the sync unit
`timescale 1ns/1ns
`default_nettype none
`include "hsu_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_hsu_sync_unit;
    localparam int TW = 8;  // short timers keep overflow quick
    localparam logic [31:0] TMAX = (32'h1 << TW) - 32'h1;
    localparam logic [31:0] CE = 32'h1 << `HSU_CTL_CMPEN;
    localparam logic [31:0] BS = 32'h1 << `HSU_CTL_BSD;
    localparam logic [31:0] GT = 32'h1 << `HSU_CTL_GATE;
    localparam logic [31:0] TS = 32'h1 << `HSU_CTL_TEST;
    localparam logic [31:0] ED = 32'h1 << `HSU_CTL_ERRDIS;
    localparam logic [31:0] BD = 32'h1 << `HSU_CTL_BCMPDIS;
    localparam logic [31:0] RS = 32'h1 << `HSU_CTL_RISE;
    localparam logic [31:0] D  = BD | ED;  // quiet break timer events
    typedef struct packed {
        logic [5:0]  a;
        logic [3:0]  s;
        logic [31:0] d;
        logic [31:0] e;
    } hsu_rrow_t;
    typedef struct packed {
        logic [31:0] c;
        int          len;
        logic [31:0] e;
    } hsu_crow_t;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        utx = 1'b1, ttx = 1'b1, watch = 1'b0, seen = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wd = 32'h0, rd, r1, r2;
    wire logic [31:0] dat_o;
    wire logic   ack, trx_txd, urx, trx, test_rx, irq;
    int          fail_count = 0, n_tests = 0;
    // register rows: write d with lanes s, read back e
    hsu_rrow_t rr [6] = '{
        '{`HSU_OFF_CTRL, 4'hf, 32'hffffffff, 32'h00001fff},
        '{`HSU_OFF_CTRL, 4'h1, 32'h0000ff60, 32'h00001f60},
        '{`HSU_OFF_CTRL, 4'hf, 32'h00000000, 32'h00000000},
        '{`HSU_OFF_SCMP, 4'hf, 32'h000000a5, 32'h000000a5},
        '{`HSU_OFF_STAT, 4'hf, 32'hffffffff, 32'h00000000},
        '{6'h14, 4'hf, 32'hffffffff, 32'h00000000}};
    // event rows: control, low length, status expected after the pulse
    hsu_crow_t cr [11] = '{
        '{BS | GT | D, 12, 32'h1}, '{BS | GT | RS | D, 12, 32'h0},
        '{RS | D, 12, 32'h1}, '{D, 12, 32'h0}, '{BS | D, 12, 32'h0},
        '{BS | ED, 30, 32'h2}, '{BS | D, 30, 32'h0},
        '{BS | BD, 300, 32'h4}, '{BS | D, 300, 32'h0},
        '{CE | BS | D, 300, 32'h8}, '{BS | D, 300, 32'h0}};
    hsu_sync_unit #(.TW(TW), .BRK_MIN(20)) u_hsu_sync_unit (
        .CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wd), .DAT_O(dat_o), .ACK_O(ack),
        .TRX_RXD_I(trx), .TRX_TXD_O(trx_txd), .UART_TXD_I(utx),
        .UART_RXD_O(urx), .TEST_TX_I(ttx), .TEST_RX_O(test_rx),
        .IRQ_O(irq));
    hsu_bus_node u_hsu_bus_node (.clk_i(clk), .txd_i(trx_txd), .bus_o(trx));
    initial begin
        forever #5 clk = ~clk;
    end
    // catches any low on the uart input while watching, clears when idle
    always @(posedge clk) begin
        if (!watch) begin
            seen <= 1'b0;
        end else if (urx === 1'b0) begin
            seen <= 1'b1;
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one classic cycle; the answer is taken at the edge that sees ack
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        sel <= s;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            fail_count++;
            conclude();
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf, rd);
    endtask
    task automatic rdr(input logic [5:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, 4'hf, q);
    endtask
    // hang guard: the whole run fits well inside this bound
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        `CHK("reset outs", 5'b11100, {trx_txd, urx, test_rx, irq, ack})
        rst <= 1'b0;
        rdr(`HSU_OFF_CTRL, rd);
        `CHK("ctrl reset", 32'h0, rd)
        foreach (rr[i]) begin
            wb(1'b1, rr[i].a, rr[i].d, rr[i].s, rd);
            rdr(rr[i].a, rd);
            `CHK("reg row", rr[i].e, rd)
        end
        // normal mode: uart drives the wire and hears it back
        utx <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("uart path", 3'b001, {trx_txd, urx, test_rx})
        utx <= 1'b1;
        // port pins assumed set up by software first
        wr(`HSU_OFF_CTRL, TS);
        ttx <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("test drive", 3'b001, {trx_txd, test_rx, urx})
        utx <= 1'b0;
        ttx <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("uart bypass", 1'b1, trx_txd)
        utx <= 1'b1;
        wr(`HSU_OFF_BRK, 32'h0000000a);
        // event rows; control changes only while the wire is released
        // the serial rows without bit 8 are write mode
        foreach (cr[i]) begin
            wr(`HSU_OFF_CTRL, cr[i].c);
            wr(`HSU_OFF_STAT, 32'h0000000f);
            u_hsu_bus_node.pulse(cr[i].len, 4);
            rdr(`HSU_OFF_STAT, rd);
            `CHK("status row", cr[i].e, rd)
            `CHK("irq row", cr[i].e != 32'h0, irq)
        end
        // pulse width in read mode, then write mode after a restart
        wr(`HSU_OFF_CTRL, BS | GT | D);
        u_hsu_bus_node.pulse(40, 4);
        rdr(`HSU_OFF_BRK, rd);
        `CHK("width read", 32'h00000027, rd)
        wr(`HSU_OFF_CTRL, BS | D);
        u_hsu_bus_node.pulse(20, 4);
        rdr(`HSU_OFF_BRK, rd);
        `CHK("width write", 32'h00000013, rd)
        // a long low stops the timer at its top value
        u_hsu_bus_node.pulse(300, 4);
        rdr(`HSU_OFF_BRK, rd);
        `CHK("overflow hold", TMAX, rd)
        // lin header: uart held idle through break and sync byte
        wr(`HSU_OFF_CTRL, GT | D);
        watch <= 1'b1;
        u_hsu_bus_node.pulse(30, 4);
        repeat (5) u_hsu_bus_node.pulse(2, 2);
        `CHK("header gated", 1'b0, seen)
        u_hsu_bus_node.pulse(6, 4);
        `CHK("data passes", 1'b1, seen)
        watch <= 1'b0;
        // reset in mid run clears outputs, status and the timer
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("reset again", 5'b11100, {trx_txd, urx, test_rx, irq, ack})
        rst <= 1'b0;
        rdr(`HSU_OFF_STAT, rd);
        `CHK("status reset", 32'h0, rd)
        rdr(`HSU_OFF_BRK, rd);
        `CHK("timer reset", 32'h0, rd)
        conclude();
    end
endmodule
`default_nettype wire

/* File: verilog/hsu_cfg.svh */
// register map, field positions and reset values of the sync unit
`ifndef HSU_CFG_SVH
`define HSU_CFG_SVH

// register byte offsets on the wishbone bus
`define HSU_OFF_CTRL     6'h00
`define HSU_OFF_STAT     6'h04
`define HSU_OFF_BRK      6'h08
`define HSU_OFF_SYNC     6'h0c
`define HSU_OFF_SCMP     6'h10

// control word fields
`define HSU_CTL_CMPEN    5
`define HSU_CTL_BSD      6
`define HSU_CTL_GATE     8
`define HSU_CTL_TEST     9
`define HSU_CTL_ERRDIS   10
`define HSU_CTL_BCMPDIS  11
`define HSU_CTL_RISE     12
`define HSU_CTL_W        13

// status word fields
`define HSU_STA_RISE     0
`define HSU_STA_BCMP     1
`define HSU_STA_BERR     2
`define HSU_STA_SCMP     3
`define HSU_STA_W        4

// reset values
`define HSU_CTL_RST      13'h0000
`define HSU_STA_RST      4'h0

// rising edges of the sync byte that follow the break delimiter
`define HSU_SYNC_RISES   3'h5

`endif

/* File: verilog/hsu_pkg.sv */
// types shared by the sync unit
package hsu_pkg;
    // header tracking states of the received frame
    typedef enum logic [1:0] {
        HDR_IDLE,
        HDR_BREAK,
        HDR_SYNC,
        HDR_DATA
    } hsu_hdr_t;
endpackage

/* File: verilog/hsu_sync_unit.sv */
// single-wire bus hardware sync unit: control, timers, status, pin routing
//
// Notes on behaviour
// - compare-disable low lets break compare interrupt through
// - control bit 10 masks break error interrupt
// - bit 9 low: transceiver wired to uart
// - bit 9 high: test pins drive transceiver
// - bit 8 high in lin mode (bit 6 low): uart input high until header
// - bit 8 low: bus data reaches uart
// - bit-serial mode needs mode bit 6 set
// - serial read: rising edge sets status bit 0
// - break timer runs falling to rising edge
// - break timer interrupts when count equals compare
// - break timer overflow raises error interrupt
// - sync compare sets status bit 3
// - break timer stops on rising edge always
// - mode bit 6: lin low, serial high
// - bit 12 rising interrupt, polarity per mode
// - compare enable bit 5 gates sync compare
`timescale 1ns/1ns
`default_nettype none
`include "hsu_cfg.svh"

module hsu_sync_unit #(
    parameter int TW      = 16,   // width of both timers
    parameter int BRK_MIN = 1024  // low cycles that make a break
) (
    input  wire logic        CLK_I,        // core clock, 100 mhz
    input  wire logic        RST_I,        // synchronous reset, high
    input  wire logic        CYC_I,        // wishbone cycle
    input  wire logic        STB_I,        // wishbone strobe
    input  wire logic        WE_I,         // wishbone write
    input  wire logic [5:0]  ADR_I,        // byte address
    input  wire logic [3:0]  SEL_I,        // byte lanes
    input  wire logic [31:0] DAT_I,        // write data
    output logic      [31:0] DAT_O,        // read data
    output logic             ACK_O,        // wishbone acknowledge
    input  wire logic        TRX_RXD_I,    // bus level from transceiver
    output logic             TRX_TXD_O,    // drive to transceiver
    input  wire logic        UART_TXD_I,   // uart transmit data
    output logic             UART_RXD_O,   // uart receive data
    input  wire logic        TEST_TX_I,    // test pin into transceiver
    output logic             TEST_RX_O,    // test pin from transceiver
    output logic             IRQ_O         // any status bit pending
);
    import hsu_pkg::*;

    localparam logic [TW-1:0] TMAX = {TW{1'b1}}; // overflow point

    // byte-lane merge, used by the control and both compare registers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // state
    logic [`HSU_CTL_W-1:0] ctl_q;     // sync_unit_control_word
    logic [`HSU_STA_W-1:0] sta_q;     // sync_unit_status_word
    logic [TW-1:0]         bt_q;      // break_pulse_timer count
    logic [TW-1:0]         bcmp_q;    // break timer compare value
    logic                  brun_q;    // break timer running
    logic [TW-1:0]         st_q;      // sync_bit_timer
    logic [TW-1:0]         scmp_q;    // sync_timer_compare
    logic                  bus_q;     // previous bus level
    logic [15:0]           low_q;     // length of current low level
    hsu_hdr_t              hdr_q;     // header tracking state
    hsu_hdr_t              hdr_d;
    logic [2:0]            rise_q;    // rising edges seen in sync byte

    // bus decode
    wire        req      = CYC_I & STB_I;
    wire        wr       = req & WE_I & ACK_O;  // write at the ack edge
    wire        hit_ctl  = ADR_I == `HSU_OFF_CTRL;
    wire        hit_sta  = ADR_I == `HSU_OFF_STAT;
    wire        hit_brk  = ADR_I == `HSU_OFF_BRK;
    wire        hit_scmp = ADR_I == `HSU_OFF_SCMP;
    wire [31:0] wdat_ctl = merge({19'h0, ctl_q}, DAT_I, SEL_I);
    wire [31:0] wdat_brk = merge({{(32-TW){1'b0}}, bcmp_q}, DAT_I, SEL_I);
    wire [31:0] wdat_sc  = merge({{(32-TW){1'b0}}, scmp_q}, DAT_I, SEL_I);
    wire [`HSU_STA_W-1:0] sta_clr = (wr & hit_sta & SEL_I[0])
                                  ? DAT_I[`HSU_STA_W-1:0] : '0;

    // unmapped offsets read as zero but are still acknowledged
    logic [31:0] rdat;
    always_comb begin
        unique case (ADR_I)
            `HSU_OFF_CTRL: rdat = {19'h0, ctl_q};
            `HSU_OFF_STAT: rdat = {28'h0, sta_q};
            `HSU_OFF_BRK:  rdat = {{(32-TW){1'b0}}, bt_q};
            `HSU_OFF_SYNC: rdat = {{(32-TW){1'b0}}, st_q};
            `HSU_OFF_SCMP: rdat = {{(32-TW){1'b0}}, scmp_q};
            default:       rdat = 32'h0000_0000;
        endcase
    end

    // control decode
    wire bit_serial_bus      = ctl_q[`HSU_CTL_BSD];
    wire test     = ctl_q[`HSU_CTL_TEST];
    wire gate     = ctl_q[`HSU_CTL_GATE];
    wire bus_fall = bus_q & ~TRX_RXD_I;
    wire bus_rise = ~bus_q & TRX_RXD_I;

    // rising edge interrupt: bit 12 disables in serial, enables in lin
    wire rise_en  = bit_serial_bus ? (gate & ~ctl_q[`HSU_CTL_RISE])
                        : ctl_q[`HSU_CTL_RISE];
    wire ev_rise  = bus_rise & rise_en;
    wire ev_bcmp  = brun_q & (bt_q == bcmp_q)
                  & ~ctl_q[`HSU_CTL_BCMPDIS];
    wire bt_ovf   = brun_q & (bt_q == TMAX);
    wire ev_berr  = bt_ovf & ~ctl_q[`HSU_CTL_ERRDIS];
    wire ev_scmp  = ctl_q[`HSU_CTL_CMPEN] & (st_q == scmp_q);
    wire [`HSU_STA_W-1:0] sta_set = {ev_scmp, ev_berr, ev_bcmp, ev_rise};

    wire brk_seen = low_q == 16'(BRK_MIN);
    wire hdr_done = hdr_q == HDR_DATA;
    // with gating on in lin mode the uart is held idle whenever the header state is not HDR_DATA
    wire uart_rx  = (gate & ~bit_serial_bus & ~hdr_done) ? 1'b1 : TRX_RXD_I;

    // wishbone answer: ack one cycle after the strobe, dropped next cycle
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ACK_O <= req & ~ACK_O;
            if (req & ~ACK_O) begin
                DAT_O <= rdat;
            end
        end
    end

    // software registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctl_q  <= `HSU_CTL_RST;
            bcmp_q <= '0;
            scmp_q <= '0;
        end else if (wr) begin
            if (hit_ctl) ctl_q <= wdat_ctl[`HSU_CTL_W-1:0];
            if (hit_brk) bcmp_q <= wdat_brk[TW-1:0];
            if (hit_scmp) scmp_q <= wdat_sc[TW-1:0];
        end
    end

    // sticky status: a set in the clearing cycle wins
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sta_q <= `HSU_STA_RST;
            IRQ_O <= 1'b0;
        end else begin
            sta_q <= (sta_q & ~sta_clr) | sta_set;
            IRQ_O <= |((sta_q & ~sta_clr) | sta_set);
        end
    end

    // break timer: falling edge restarts, rising edge or overflow stops
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bt_q   <= '0;
            brun_q <= 1'b0;
        end else if (bus_fall) begin
            bt_q   <= '0;
            brun_q <= 1'b1;
        end else if (bus_rise | bt_ovf) begin
            brun_q <= 1'b0;
        end else if (brun_q) begin
            bt_q   <= bt_q + 1'b1;
        end
    end

    // sync bit timer restarts at falling edges and otherwise wraps
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_q <= '0;
        end else begin
            st_q <= bus_fall ? '0 : st_q + 1'b1;
        end
    end

    // bus edge tracking and low length, saturating at the break length
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bus_q <= 1'b1;
            low_q <= 16'h0000;
        end else begin
            bus_q <= TRX_RXD_I;
            if (TRX_RXD_I) begin
                low_q <= 16'h0000;
            end else if (!brk_seen) begin
                low_q <= low_q + 16'h0001;
            end
        end
    end

    // header tracking: break, then the five rises of the sync byte
    always_comb begin
        hdr_d = hdr_q;
        // only while still low: the closing rise of the break must reach
        // the case below, or the delimiter rise would be lost
        if (brk_seen && !TRX_RXD_I) begin
            hdr_d = HDR_BREAK;
        end else begin
            unique case (hdr_q)
                HDR_IDLE:  hdr_d = HDR_IDLE;
                HDR_BREAK: if (bus_rise) hdr_d = HDR_SYNC;
                HDR_SYNC:  if (bus_rise && rise_q == `HSU_SYNC_RISES - 3'h1)
                               hdr_d = HDR_DATA;
                HDR_DATA:  hdr_d = HDR_DATA;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            hdr_q  <= HDR_IDLE;
            rise_q <= 3'h0;
        end else begin
            hdr_q  <= hdr_d;
            if (hdr_q != HDR_SYNC) begin
                rise_q <= 3'h0;
            end else if (bus_rise) begin
                rise_q <= rise_q + 3'h1;
            end
        end
    end

    // pin routing; test mode bypasses the uart in both directions
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            TRX_TXD_O  <= 1'b1;
            UART_RXD_O <= 1'b1;
            TEST_RX_O  <= 1'b1;
        end else begin
            TRX_TXD_O  <= test ? TEST_TX_I : UART_TXD_I;
            UART_RXD_O <= test ? 1'b1 : uart_rx;
            TEST_RX_O  <= test ? TRX_RXD_I : 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    property p_bcmp;
        brun_q && bt_q == bcmp_q && !ctl_q[`HSU_CTL_BCMPDIS]
            |=> sta_q[`HSU_STA_BCMP];
    endproperty
    a_bcmp: assert property (p_bcmp)
        else $error("break compare did not set status");

    property p_errmask;
        $rose(sta_q[`HSU_STA_BERR]) |-> !$past(ctl_q[`HSU_CTL_ERRDIS]);
    endproperty
    a_errmask: assert property (p_errmask)
        else $error("masked break error set status");

    property p_normal;
        !test |=> TRX_TXD_O == $past(UART_TXD_I) && TEST_RX_O;
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal mode routing wrong");

    property p_testmode;
        test |=> TRX_TXD_O == $past(TEST_TX_I) && UART_RXD_O
                 && TEST_RX_O == $past(TRX_RXD_I);
    endproperty
    a_testmode: assert property (p_testmode)
        else $error("test mode routing wrong");

    property p_gate;
        !test && gate && !bit_serial_bus && !hdr_done |=> UART_RXD_O;
    endproperty
    a_gate: assert property (p_gate)
        else $error("uart input not held high during header");

    property p_bsdrise;
        bit_serial_bus && gate && !ctl_q[`HSU_CTL_RISE] && bus_rise
            |=> sta_q[`HSU_STA_RISE];
    endproperty
    a_bsdrise: assert property (p_bsdrise)
        else $error("serial rising edge lost");

    property p_bwidth;
        bus_fall ##1 (!bus_rise && !bt_ovf) [*3] |=> bt_q == TW'(3) && brun_q;
    endproperty
    a_bwidth: assert property (p_bwidth)
        else $error("break timer width wrong");

    property p_ovf;
        brun_q && bt_q == TMAX && !ctl_q[`HSU_CTL_ERRDIS]
            |=> sta_q[`HSU_STA_BERR] && !brun_q;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow not reported");

    property p_linrise;
        !bit_serial_bus && !ctl_q[`HSU_CTL_RISE] |=> !$rose(sta_q[`HSU_STA_RISE]);
    endproperty
    a_linrise: assert property (p_linrise)
        else $error("lin rising edge not masked");

    property p_scmp;
        ctl_q[`HSU_CTL_CMPEN] && st_q == scmp_q |=> sta_q[`HSU_STA_SCMP];
    endproperty
    a_scmp: assert property (p_scmp)
        else $error("sync compare did not set status");

    property p_stop;
        bus_rise |=> !brun_q;
    endproperty
    a_stop: assert property (p_stop)
        else $error("break timer kept running after rise");

    c_header: cover property (hdr_q == HDR_SYNC ##[1:1000] hdr_done);
    c_bsdread: cover property (bit_serial_bus && gate && ev_rise);
    c_test: cover property (test && !TRX_RXD_I);
    c_ovf: cover property (ev_berr);

endmodule
`default_nettype wire
